/* shared/pai_pkg.sv */
// Shared constants and types for the port alias and indirect access block
package pai_pkg;

    // ========================================
    // Main-space register offsets
    localparam logic [7:0] OFF_PORT_SELECT = 8'h4c;
    localparam logic [7:0] OFF_IND_CTL = 8'hb0;
    localparam logic [7:0] OFF_IND_OFFSET = 8'hb1;
    localparam logic [7:0] OFF_IND_DATA = 8'hb2;
    localparam logic [7:0] OFF_PORT0_ALIAS = 8'hf8;
    localparam logic [7:0] OFF_PORT1_ALIAS = 8'hf9;
    localparam logic [7:0] OFF_PORT2_ALIAS = 8'hfa;
    localparam logic [7:0] OFF_PORT3_ALIAS = 8'hfb;
    localparam logic [7:0] OFF_RSVD_FIRST = 8'hfc;
    localparam logic [7:0] OFF_RSVD_LAST = 8'hff;

    // ========================================
    // Field positions
    localparam int ALIAS_MSB = 7;
    localparam int ALIAS_LSB = 1;
    localparam int CTL_SEL_MSB = 5;
    localparam int CTL_SEL_LSB = 2;
    localparam int CTL_AUTO_INC = 1;
    localparam int PSEL_MSB = 1;
    localparam int PSEL_LSB = 0;

    // ========================================
    // Reset values and write masks
    localparam logic [7:0] ALIAS_RESET = 8'h00;
    localparam logic [7:0] RSVD_RESET = 8'h00;
    localparam logic [7:0] IND_CTL_RESET = 8'h00;
    localparam logic [7:0] IND_OFFSET_RESET = 8'h00;
    localparam logic [7:0] PORT_SELECT_RESET = 8'h00;
    localparam logic [7:0] IND_CTL_MASK = 8'h3e;
    localparam logic [7:0] ALIAS_MASK = 8'hfe;
    localparam logic [7:0] IND_MEM_RESET = 8'h00;

    // ========================================
    // Indirect block select codes and ranges
    localparam logic [3:0] SEL_DIG_PAGE0 = 4'h0;
    localparam logic [3:0] SEL_RX_CH0 = 4'h1;
    localparam logic [3:0] SEL_RX_CH3 = 4'h4;
    localparam logic [3:0] SEL_RX_SHARED = 4'h5;
    localparam logic [3:0] SEL_RX_BCAST = 4'h6;
    localparam logic [3:0] SEL_CSI_RSVD = 4'h7;
    localparam logic [7:0] PGEN_FIRST = 8'h01;
    localparam logic [7:0] PGEN_LAST = 8'h1f;
    localparam logic [7:0] CSI_TIM_FIRST = 8'h40;
    localparam logic [7:0] CSI_TIM_LAST = 8'h51;
    localparam logic [7:0] RX_CH_LAST = 8'h14;
    localparam logic [7:0] RX_SHARED_LAST = 8'h04;
    localparam logic [7:0] CSI_RSVD_LAST = 8'h1d;

    // Main control-bus address of the device; value is arbitrary
    localparam logic [6:0] MAIN_DEV_ADDR = 7'h3d;

    // ========================================
    // Types
    typedef struct packed {
        logic [6:0] dev_addr;
        logic wr;
        logic [7:0] offset;
        logic [7:0] wdata;
    } pai_req_t;

    typedef struct packed {
        logic [1:0] port;
        logic wr;
        logic [7:0] offset;
        logic [7:0] wdata;
    } pai_ext_t;

endpackage

/* rtl/pai_ind_mem.sv */
// Indirect register pages behind the three-register access window
`timescale 1ns/1ps

module pai_ind_mem (
    // Clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // Access
    input wire logic [3:0] sel,
    input wire logic [7:0] offset,
    input wire logic wr_en,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata
);

    // ========================================
    // Read word of each page at the current offset
    wire logic [7:0] page_rd [0:7];
    logic in_range;
    logic [2:0] rd_page;

    // Defined offsets per selected block
    always_comb begin
        in_range = 1'b0;
        rd_page = sel[2:0];
        unique case (sel)
            pai_pkg::SEL_DIG_PAGE0: begin
                in_range = (offset >= pai_pkg::PGEN_FIRST &&
                            offset <= pai_pkg::PGEN_LAST) ||
                           (offset >= pai_pkg::CSI_TIM_FIRST &&
                            offset <= pai_pkg::CSI_TIM_LAST); // [R14] [R15]
            end
            4'h1, 4'h2, 4'h3, 4'h4: begin
                in_range = offset <= pai_pkg::RX_CH_LAST; // [R16]
            end
            pai_pkg::SEL_RX_SHARED: begin
                in_range = offset <= pai_pkg::RX_SHARED_LAST; // [R17]
            end
            pai_pkg::SEL_RX_BCAST: begin
                in_range = offset <= pai_pkg::RX_CH_LAST; // [R18]
                rd_page = pai_pkg::SEL_RX_CH0[2:0]; // Reads see channel 0
            end
            pai_pkg::SEL_CSI_RSVD: begin
                in_range = offset <= pai_pkg::CSI_RSVD_LAST; // [R19]
            end
            default: begin
                in_range = 1'b0;
            end
        endcase
    end

    // Read path; undefined offsets return zero
    always_comb begin
        rdata = in_range ? page_rd[rd_page] : 8'h00; // [R10] [R23]
    end

    // ========================================
    // One array per page; the broadcast code owns no storage of its own
    // Broadcast writes reach the four channel pages
    genvar p;
    generate
        for (p = 0; p < 8; p++) begin : g_page
            if (p == int'(pai_pkg::SEL_RX_BCAST)) begin : g_none
                assign page_rd[p] = 8'h00;
            end else begin : g_store
                logic [7:0] page_q [0:127];
                logic hit;
                assign hit = wr_en && in_range &&
                    ((sel == 4'(p)) ||
                     (sel == pai_pkg::SEL_RX_BCAST &&
                      4'(p) >= pai_pkg::SEL_RX_CH0 &&
                      4'(p) <= pai_pkg::SEL_RX_CH3)); // [R18]
                assign page_rd[p] = page_q[offset[6:0]];

                // Page storage
                always_ff @(posedge clock or negedge arst_n) begin
                    if (!arst_n) begin
                        for (int i = 0; i < 128; i++) begin
                            page_q[i] <= pai_pkg::IND_MEM_RESET;
                        end
                    end else if (hit) begin
                        page_q[offset[6:0]] <= wdata; // [R9] [R23]
                    end
                end
            end
        end
    endgenerate

endmodule

/* rtl/pai_regs.sv */
// Alias decode, paging and indirect access window of the control bus
//
// Function
// (R1) Ports 1-3 have 7-bit alias field, bit0 zero
// (R2) Nonzero alias match reaches that port's registers
// (R3) Alias accesses also reach all shared registers
// (R4) Alias field zero disables that port's decoder
// (R5) Port 3 alias at 0xFB, resets to zero
// (R6) Offsets 0xFC-0xFF reserved, reset zero
// (R7) Indirect control/offset/data at 0xB0-0xB2
// (R8) Host writes block select, then offset
// (R9) Data write stores byte in chosen register
// (R10) Data read returns chosen indirect register
// (R11) Auto-increment advances offset after data access
// (R12) Auto-increment writes land in successive offsets
// (R13) Auto-increment reads return successive offsets
// (R14) Select 0000: pattern generator 0x01-0x1F
// (R15) Select 0000: transmit timing 0x40-0x51
// (R16) Selects 0001-0100: channel pages 0x00-0x14
// (R17) Select 0101: shared receive page 0x00-0x04
// (R18) Select 0110: write all four channel pages
// (R19) Select 0111: transmit reserved page 0x00-0x1D
// (R20) Port select at 0x4C pages port registers
// (R21) Port 0 alias at 0xF8, zero disables
// (R22) Offset and data 8 bits, offset wraps
// (R23) Undefined indirect offsets ignore writes, read zero
`timescale 1ns/1ps

module pai_regs (
    // Clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // Decoded control-bus transaction
    input wire logic req_valid,
    input wire pai_pkg::pai_req_t req,
    // Answer, two cycles after the request
    output logic rsp_valid,
    output logic rsp_ack,
    output logic [7:0] rsp_rdata,
    // Forward to the rest of the register space
    output logic ext_valid,
    output pai_pkg::pai_ext_t ext,
    input wire logic [7:0] ext_rdata,
    // Block state
    output logic [1:0] page_port,
    output logic [3:0] alias_enabled
);

    // ========================================
    // Registers
    logic [7:0] alias_q [0:3];
    logic [7:0] alias_d [0:3];
    logic [7:0] port_sel_q, port_sel_d;
    logic [7:0] ind_ctl_q, ind_ctl_d;
    logic [7:0] ind_off_q, ind_off_d;

    // First stage: decode result and local read data
    logic s1_valid_q, s1_valid_d;
    logic s1_ack_q, s1_ack_d;
    logic s1_local_q, s1_local_d;
    logic [7:0] s1_rdata_q, s1_rdata_d;

    // Output stage
    logic rsp_valid_q, rsp_valid_d;
    logic rsp_ack_q, rsp_ack_d;
    logic [7:0] rsp_rdata_q, rsp_rdata_d;
    logic ext_valid_q, ext_valid_d;
    pai_pkg::pai_ext_t ext_q, ext_d;
    logic [1:0] page_port_q, page_port_d;
    logic [3:0] alias_en_q, alias_en_d;

    // Decode helpers
    logic [3:0] alias_hit;
    logic main_hit;
    logic addr_hit;
    logic [1:0] tgt_port;
    logic is_local;
    logic data_acc;
    logic [7:0] local_rdata;
    logic [7:0] ind_rdata;
    logic ind_wr;

    // ========================================
    // Alias decoders, one per receive port
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_alias
            logic [6:0] fld;
            assign fld = alias_q[g][pai_pkg::ALIAS_MSB:pai_pkg::ALIAS_LSB];
            assign alias_hit[g] = (fld != 7'h00) &&
                                  (fld == req.dev_addr); // [R2] [R4] [R21]
        end
    endgenerate

    // Target selection: main address pages, alias fixes the port
    always_comb begin
        main_hit = req.dev_addr == pai_pkg::MAIN_DEV_ADDR;
        addr_hit = main_hit || (alias_hit != 4'h0);
        tgt_port = port_sel_q[pai_pkg::PSEL_MSB:pai_pkg::PSEL_LSB]; // [R20]
        if (!main_hit) begin
            if (alias_hit[0]) begin
                tgt_port = 2'd0;
            end else if (alias_hit[1]) begin
                tgt_port = 2'd1;
            end else if (alias_hit[2]) begin
                tgt_port = 2'd2;
            end else begin
                tgt_port = 2'd3; // [R2]
            end
        end
    end

    // Local register decode and read mux, shared by any address
    always_comb begin
        is_local = 1'b1; // [R3]
        local_rdata = 8'h00;
        unique case (req.offset)
            pai_pkg::OFF_PORT_SELECT: local_rdata = port_sel_q; // [R20]
            pai_pkg::OFF_IND_CTL: local_rdata = ind_ctl_q; // [R7]
            pai_pkg::OFF_IND_OFFSET: local_rdata = ind_off_q; // [R7]
            pai_pkg::OFF_IND_DATA: local_rdata = ind_rdata; // [R10] [R13]
            pai_pkg::OFF_PORT0_ALIAS: local_rdata = alias_q[0]; // [R21]
            pai_pkg::OFF_PORT1_ALIAS: local_rdata = alias_q[1]; // [R1]
            pai_pkg::OFF_PORT2_ALIAS: local_rdata = alias_q[2]; // [R1]
            pai_pkg::OFF_PORT3_ALIAS: local_rdata = alias_q[3]; // [R5]
            8'hfc, 8'hfd, 8'hfe, 8'hff: local_rdata = pai_pkg::RSVD_RESET; // [R6]
            default: is_local = 1'b0;
        endcase
        data_acc = req_valid && addr_hit &&
                   req.offset == pai_pkg::OFF_IND_DATA;
        ind_wr = data_acc && req.wr; // [R9]
    end

    // ========================================
    // Indirect pages
    pai_ind_mem u_ind_mem (
        .clock(clock),
        .arst_n(arst_n),
        .sel(ind_ctl_q[pai_pkg::CTL_SEL_MSB:pai_pkg::CTL_SEL_LSB]), // [R14]
        .offset(ind_off_q),
        .wr_en(ind_wr),
        .wdata(req.wdata),
        .rdata(ind_rdata)
    );

    // ========================================
    // Next values of the software registers
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            alias_d[i] = alias_q[i];
        end
        port_sel_d = port_sel_q;
        ind_ctl_d = ind_ctl_q;
        ind_off_d = ind_off_q;
        if (req_valid && addr_hit && req.wr) begin
            unique case (req.offset)
                pai_pkg::OFF_PORT_SELECT: port_sel_d = req.wdata; // [R20]
                pai_pkg::OFF_IND_CTL:
                    ind_ctl_d = req.wdata & pai_pkg::IND_CTL_MASK; // [R8]
                pai_pkg::OFF_IND_OFFSET: ind_off_d = req.wdata; // [R8] [R22]
                pai_pkg::OFF_PORT0_ALIAS:
                    alias_d[0] = req.wdata & pai_pkg::ALIAS_MASK; // [R21]
                pai_pkg::OFF_PORT1_ALIAS:
                    alias_d[1] = req.wdata & pai_pkg::ALIAS_MASK; // [R1]
                pai_pkg::OFF_PORT2_ALIAS:
                    alias_d[2] = req.wdata & pai_pkg::ALIAS_MASK; // [R1]
                pai_pkg::OFF_PORT3_ALIAS:
                    alias_d[3] = req.wdata & pai_pkg::ALIAS_MASK; // [R1]
                default: begin
                end
            endcase
        end
        // With auto-increment set, offset advances after each data access, wrapping at 256
        if (data_acc && ind_ctl_q[pai_pkg::CTL_AUTO_INC]) begin
            ind_off_d = ind_off_q + 8'h01; // [R11] [R12] [R13] [R22]
        end
    end

    // Software registers
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < 4; i++) begin
                alias_q[i] <= pai_pkg::ALIAS_RESET; // [R5] [R4]
            end
            port_sel_q <= pai_pkg::PORT_SELECT_RESET;
            ind_ctl_q <= pai_pkg::IND_CTL_RESET;
            ind_off_q <= pai_pkg::IND_OFFSET_RESET;
        end else begin
            for (int i = 0; i < 4; i++) begin
                alias_q[i] <= alias_d[i];
            end
            port_sel_q <= port_sel_d;
            ind_ctl_q <= ind_ctl_d;
            ind_off_q <= ind_off_d;
        end
    end

    // ========================================
    // Answer pipeline and forwarding
    always_comb begin
        s1_valid_d = req_valid;
        s1_ack_d = req_valid && addr_hit;
        s1_local_d = is_local;
        s1_rdata_d = local_rdata;
        ext_valid_d = req_valid && addr_hit && !is_local; // [R2] [R3]
        ext_d = ext_q;
        if (req_valid) begin
            ext_d.port = tgt_port; // [R2] [R20]
            ext_d.wr = req.wr;
            ext_d.offset = req.offset;
            ext_d.wdata = req.wdata;
        end
        rsp_valid_d = s1_valid_q;
        rsp_ack_d = s1_ack_q;
        rsp_rdata_d = 8'h00;
        if (s1_ack_q) begin
            rsp_rdata_d = s1_local_q ? s1_rdata_q : ext_rdata;
        end
        page_port_d = port_sel_q[pai_pkg::PSEL_MSB:pai_pkg::PSEL_LSB];
        for (int i = 0; i < 4; i++) begin
            alias_en_d[i] =
                alias_q[i][pai_pkg::ALIAS_MSB:pai_pkg::ALIAS_LSB] != 7'h00;
        end
    end

    // Pipeline registers
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            s1_valid_q <= 1'b0;
            s1_ack_q <= 1'b0;
            s1_local_q <= 1'b0;
            s1_rdata_q <= 8'h00;
            ext_valid_q <= 1'b0;
            ext_q <= '0;
            rsp_valid_q <= 1'b0;
            rsp_ack_q <= 1'b0;
            rsp_rdata_q <= 8'h00;
            page_port_q <= 2'd0;
            alias_en_q <= 4'h0;
        end else begin
            s1_valid_q <= s1_valid_d;
            s1_ack_q <= s1_ack_d;
            s1_local_q <= s1_local_d;
            s1_rdata_q <= s1_rdata_d;
            ext_valid_q <= ext_valid_d;
            ext_q <= ext_d;
            rsp_valid_q <= rsp_valid_d;
            rsp_ack_q <= rsp_ack_d;
            rsp_rdata_q <= rsp_rdata_d;
            page_port_q <= page_port_d;
            alias_en_q <= alias_en_d;
        end
    end

    // Outputs straight from flip-flops
    assign rsp_valid = rsp_valid_q;
    assign rsp_ack = rsp_ack_q;
    assign rsp_rdata = rsp_rdata_q;
    assign ext_valid = ext_valid_q;
    assign ext = ext_q;
    assign page_port = page_port_q;
    assign alias_enabled = alias_en_q;

endmodule

/* dv/pai_regs_chk.sv */
// Checker bound to the port alias and indirect access block
`timescale 1ns/1ps

module pai_regs_chk (
    // Clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // Request side
    input wire logic req_valid,
    input wire pai_pkg::pai_req_t req,
    // Answer side
    input wire logic rsp_valid,
    input wire logic rsp_ack,
    input wire logic [7:0] rsp_rdata,
    // Forward side
    input wire logic ext_valid,
    input wire pai_pkg::pai_ext_t ext,
    input wire logic [7:0] ext_rdata,
    // Block state
    input wire logic [1:0] page_port,
    input wire logic [3:0] alias_enabled
);
    // ========================================
    // Timing and contents of answers and forwards
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!arst_n);

    a_answer_delay: assert property (
        req_valid |-> ##2 rsp_valid) else $error("answer not two cycles late");
    a_answer_cause: assert property (
        rsp_valid |-> $past(req_valid, 2)) else $error("answer without request");
    a_fwd_cause: assert property (
        ext_valid |-> $past(req_valid)
            && $past(req.offset) != pai_pkg::OFF_IND_CTL
            && $past(req.offset) != pai_pkg::OFF_IND_OFFSET
            && $past(req.offset) != pai_pkg::OFF_IND_DATA
            && $past(req.offset) != pai_pkg::OFF_PORT_SELECT
            && $past(req.offset) < pai_pkg::OFF_PORT0_ALIAS)
        else $error("forward without cause");
    a_main_acked: assert property (
        req_valid && req.dev_addr == pai_pkg::MAIN_DEV_ADDR |-> ##2 rsp_ack)
        else $error("main address not acknowledged");
    a_nack_quiet: assert property (
        req_valid && req.dev_addr != pai_pkg::MAIN_DEV_ADDR
            ##1 alias_enabled == 4'h0 |-> !ext_valid ##1 (rsp_valid && !rsp_ack))
        else $error("unmatched access not refused");
    a_nack_zero: assert property (
        rsp_valid && !rsp_ack |-> rsp_rdata == 8'h00)
        else $error("refused access returned data");
    a_idle_zero: assert property (
        !rsp_valid |-> rsp_rdata == 8'h00) else $error("read data not cleared");
    a_fwd_fields: assert property (
        ext_valid |-> ext.offset == $past(req.offset)
            && ext.wr == $past(req.wr) && ext.wdata == $past(req.wdata))
        else $error("forward fields differ from request");
    a_fwd_data: assert property (
        ext_valid && !ext.wr |=> rsp_valid && rsp_rdata == $past(ext_rdata))
        else $error("forward read data lost");
    a_page_port: assert property (
        ext_valid && $past(req.dev_addr) == pai_pkg::MAIN_DEV_ADDR
            && $stable(page_port) |-> ext.port == page_port)
        else $error("paged port not used");

    // Main scenarios reached
    c_nack: cover property (rsp_valid && !rsp_ack);
    c_fwd_read: cover property (ext_valid && !ext.wr);
    c_alias_port: cover property (ext_valid && ext.port == 2'h1);
    c_fwd_write: cover property (ext_valid && ext.wr);
endmodule

bind pai_regs pai_regs_chk u_chk (.clock, .arst_n, .req_valid, .req,
    .rsp_valid, .rsp_ack, .rsp_rdata, .ext_valid, .ext, .ext_rdata,
    .page_port, .alias_enabled);

/* dv/pai_far_model.sv */
// Model of the register space that answers forwarded accesses
`timescale 1ns/1ps

module pai_far_model (
    // Clock
    clock,
    // Forward port
    ext_valid,
    ext,
    ext_rdata
);
    input wire logic clock;
    input wire logic ext_valid;
    input wire pai_pkg::pai_ext_t ext;
    output logic [7:0] ext_rdata;

    logic [7:0] noise_q = 8'h00;

    // Pattern that moves every cycle, returned outside a forward
    always @(posedge clock) begin
        noise_q <= noise_q + 8'h3b;
    end

    // Answer tagged with port and offset
    assign ext_rdata = ext_valid ? {ext.port, 1'b1, ext.offset[4:0]}
                                 : noise_q;
endmodule

/* dv/test_port_alias_and_indirect_access.sv */
// Self-checking bench for the port alias and indirect access block
`timescale 1ns/1ps

module test_port_alias_and_indirect_access;
    // ========================================
    // Signals and instances
    logic clock, arst_n, req_valid, rsp_valid, rsp_ack, ext_valid, ak;
    pai_pkg::pai_req_t req;
    pai_pkg::pai_ext_t ext;
    logic [7:0] rsp_rdata, ext_rdata, rd;
    logic [1:0] page_port;
    logic [3:0] alias_enabled;
    int n_fail = 0;
    int checked = 0;
    logic [3:0] sel_tab [8] = '{4'h0, 4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h7};
    logic [7:0] last_tab [8] = '{8'h1f, 8'h51, 8'h14, 8'h14, 8'h14, 8'h14,
                                 8'h04, 8'h1d};

    pai_regs dut (.clock(clock), .arst_n(arst_n), .req_valid(req_valid),
        .req(req), .rsp_valid(rsp_valid), .rsp_ack(rsp_ack),
        .rsp_rdata(rsp_rdata), .ext_valid(ext_valid), .ext(ext),
        .ext_rdata(ext_rdata), .page_port(page_port),
        .alias_enabled(alias_enabled));
    pai_far_model far (.clock(clock), .ext_valid(ext_valid), .ext(ext),
        .ext_rdata(ext_rdata));

    // Clock at 100 MHz
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // ========================================
    // Access and compare tasks
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic acc(input logic [6:0] a, input logic w,
                       input logic [7:0] o, input logic [7:0] d);
        int k;
        @(posedge clock);
        req_valid <= 1'b1;
        req <= '{dev_addr: a, wr: w, offset: o, wdata: d};
        @(posedge clock);
        req_valid <= 1'b0;
        k = 0;
        do begin
            @(posedge clock);
            #1;
            k++;
        end while (rsp_valid !== 1'b1 && k < 4);
        if (rsp_valid !== 1'b1) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, rsp_valid, 1);
        end
        rd = rsp_rdata;
        ak = rsp_ack;
    endtask

    task automatic wr(input logic [7:0] o, input logic [7:0] d);
        acc(pai_pkg::MAIN_DEV_ADDR, 1'b1, o, d);
    endtask

    task automatic rdc(input logic [7:0] o, input logic [7:0] exp);
        acc(pai_pkg::MAIN_DEV_ADDR, 1'b0, o, 8'h00);
        cmp(rd, exp);
    endtask

    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Watchdog well beyond the expected run
    initial begin
        #200000;
        n_fail++;
        complete_run();
    end

    // ========================================
    // Test sequence
    initial begin
        req_valid = 1'b0;
        req = '0;
        arst_n = 1'b0;
        repeat (2) @(posedge clock);
        arst_n <= 1'b1;
        // Reset values of the local registers
        for (int a = 8'hf8; a <= 8'hff; a++) begin
            rdc(a[7:0], 8'h00);
        end
        rdc(pai_pkg::OFF_IND_CTL, 8'h00);
        // Disabled alias refuses, programmed alias decodes
        acc(7'h22, 1'b0, 8'h10, 8'h00);
        cmp({7'h0, ak}, 8'h00);
        wr(pai_pkg::OFF_PORT1_ALIAS, 8'h45);
        wr(pai_pkg::OFF_PORT3_ALIAS, 8'h41);
        rdc(pai_pkg::OFF_PORT1_ALIAS, 8'h44);
        rdc(pai_pkg::OFF_PORT3_ALIAS, 8'h40);
        cmp({4'h0, alias_enabled}, 8'h0a);
        acc(7'h22, 1'b0, 8'h10, 8'h00);
        cmp(rd, 8'h70);
        cmp({6'h0, ext.port}, 8'h01);
        acc(7'h22, 1'b0, pai_pkg::OFF_PORT3_ALIAS, 8'h00);
        cmp(rd, 8'h40);
        wr(pai_pkg::OFF_PORT1_ALIAS, 8'h00);
        acc(7'h22, 1'b0, 8'h10, 8'h00);
        cmp({7'h0, ak}, 8'h00);
        // Port 0 and port 2 aliases reach their own ports
        wr(pai_pkg::OFF_PORT0_ALIAS, 8'h30);
        wr(pai_pkg::OFF_PORT2_ALIAS, 8'h32);
        acc(7'h18, 1'b0, 8'h05, 8'h00);
        cmp(rd, 8'h25);
        acc(7'h19, 1'b0, 8'h05, 8'h00);
        cmp(rd, 8'ha5);
        cmp({4'h0, alias_enabled}, 8'h0d);
        // Reserved tail and paging, forwarded read and write
        wr(8'hfc, 8'hff);
        rdc(8'hfc, 8'h00);
        wr(pai_pkg::OFF_PORT_SELECT, 8'h03);
        cmp({6'h0, page_port}, 8'h03);
        rdc(8'h10, 8'hf0);
        wr(8'h10, 8'h99);
        cmp(ext.wdata, 8'h99);
        cmp({6'h0, ext.port}, 8'h03);
        wr(pai_pkg::OFF_IND_CTL, 8'hff);
        rdc(pai_pkg::OFF_IND_CTL, 8'h3e);
        // Last offset of every page, then the first undefined one
        for (int i = 0; i < 8; i++) begin
            wr(pai_pkg::OFF_IND_CTL, {2'b00, sel_tab[i], 2'b10});
            wr(pai_pkg::OFF_IND_OFFSET, last_tab[i]);
            wr(pai_pkg::OFF_IND_DATA, 8'hc0 + 8'(i));
            wr(pai_pkg::OFF_IND_DATA, 8'h3c);
            wr(pai_pkg::OFF_IND_OFFSET, last_tab[i]);
            rdc(pai_pkg::OFF_IND_DATA, 8'hc0 + 8'(i));
            rdc(pai_pkg::OFF_IND_DATA, 8'h00);
            rdc(pai_pkg::OFF_IND_OFFSET, last_tab[i] + 8'h02);
        end
        // Channel pages kept apart, offset fixed without auto-increment
        wr(pai_pkg::OFF_IND_CTL, 8'h0c);
        wr(pai_pkg::OFF_IND_OFFSET, 8'h14);
        rdc(pai_pkg::OFF_IND_DATA, 8'hc4);
        rdc(pai_pkg::OFF_IND_DATA, 8'hc4);
        rdc(pai_pkg::OFF_IND_OFFSET, 8'h14);
        // Broadcast write reaches all four channel pages
        wr(pai_pkg::OFF_IND_CTL, 8'h18);
        wr(pai_pkg::OFF_IND_OFFSET, 8'h03);
        wr(pai_pkg::OFF_IND_DATA, 8'h5a);
        for (int s = 1; s <= 4; s++) begin
            wr(pai_pkg::OFF_IND_CTL, {2'b00, 4'(s), 2'b00});
            wr(pai_pkg::OFF_IND_OFFSET, 8'h03);
            rdc(pai_pkg::OFF_IND_DATA, 8'h5a);
        end
        // Burst into the timing registers, then the offset wraps
        wr(pai_pkg::OFF_IND_CTL, 8'h02);
        wr(pai_pkg::OFF_IND_OFFSET, 8'h40);
        wr(pai_pkg::OFF_IND_DATA, 8'ha1);
        wr(pai_pkg::OFF_IND_DATA, 8'ha2);
        wr(pai_pkg::OFF_IND_OFFSET, 8'h40);
        rdc(pai_pkg::OFF_IND_DATA, 8'ha1);
        rdc(pai_pkg::OFF_IND_DATA, 8'ha2);
        wr(pai_pkg::OFF_IND_OFFSET, 8'hff);
        wr(pai_pkg::OFF_IND_DATA, 8'h11);
        rdc(pai_pkg::OFF_IND_OFFSET, 8'h00);
        // Reset in mid-run clears the programmed aliases
        @(posedge clock);
        arst_n <= 1'b0;
        repeat (2) @(posedge clock);
        arst_n <= 1'b1;
        rdc(pai_pkg::OFF_PORT3_ALIAS, 8'h00);
        cmp({4'h0, alias_enabled}, 8'h00);
        complete_run();
    end
endmodule
